/* File: rtl/erpc_defs.vh */
`ifndef ERPC_DEFS_VH
`define ERPC_DEFS_VH
`define ERPC_ADDR_EXT_LSB_A 8'h76
`define ERPC_ADDR_EXT_LSB_B 8'h77
`define ERPC_ADDR_CFG_C 8'h78
`define ERPC_ADDR_OVERTEMP_LINE_TMR 8'h79
`define ERPC_ADDR_OVERTEMP_LINE_LIM 8'h7A
`define ERPC_ADDR_CFG_E 8'h7C
`define ERPC_ADDR_CFG_D 8'h7D
`define ERPC_ADDR_CFG_A 8'h40
`define ERPC_ADDR_MSB_V12 8'h24
`define ERPC_ADDR_MSB_R1 8'h25
`define ERPC_ADDR_MSB_LT 8'h26
`define ERPC_ADDR_MSB_R2 8'h27
`define ERPC_RST_CFG_C 8'h00
`define ERPC_RST_CFG_D 8'h00
`define ERPC_RST_CFG_E 8'h00
`define ERPC_RST_LIM 8'h00
`define ERPC_CFG_ALERT 0
`define ERPC_CFG_OVT 1
`define ERPC_CFG_FAILSAFE_FULL_FAN 2
`define ERPC_CFG_FAST 3
`define ERPC_LOCK_BIT 1
`define ERPC_LOCK_MASK 8'h0F
`define ERPC_E_BIDIR_LO 5
`define ERPC_E_BIDIR_HI 7
`define ERPC_P14_TACH 2'h0
`define ERPC_P14_SEL 2'h1
`define ERPC_P14_ALERT 2'h2
`define ERPC_P14_BAD 2'h3
`define ERPC_CLK_HZ 50000000
`define ERPC_TICK_US 22760
`define ERPC_SLOW_MS 1000
`define ERPC_FAST_MS 250
`endif

/* File: rtl/erpc_top.v */
`include "erpc_defs.vh"
`default_nettype none
module erpc_top #(
  parameter SLOW_CYC = `ERPC_CLK_HZ / 1000 * `ERPC_SLOW_MS,
  parameter FAST_CYC = `ERPC_CLK_HZ / 1000 * `ERPC_FAST_MS,
  parameter TICK_CYC = `ERPC_CLK_HZ / 1000000 * `ERPC_TICK_US
) (
  input wire CLK, // 50 MHz clock
  input wire RSTN, // sync reset, low
  input wire [7:0] REG_ADDR, // register address
  input wire REG_WR, // write strobe
  input wire [7:0] REG_WDATA, // write data
  input wire REG_RD, // read strobe
  output reg [7:0] REG_RDATA, // read data, next cycle
  input wire [9:0] TWELVE_VOLT_INPUT, // 10-bit 12 V result
  input wire [9:0] REMOTE_ONE_TEMP, // 10-bit remote one
  input wire [9:0] LOCAL_TEMP, // 10-bit local temp
  input wire [9:0] REMOTE_TWO_TEMP, // 10-bit remote two
  input wire CONV_DONE, // new results valid pulse
  input wire ALERT_REQ, // out-of-limit alert request
  input wire FAN_DRIVE_TWO_IN, // fan_drive_output_two from generator
  input wire FANS_RUNNING, // fans running
  input wire OVERTEMP_LINE_I, // overtemp pin, async, high active
  input wire OVERTEMP_REQ, // request to drive overtemp out
  output reg SHARED_PIN_O, // pin 10 level
  output reg SHARED_IS_ALERT, // pin 10 in alert mode
  output reg OVERTEMP_LINE_O, // overtemp pin drive level
  output reg OVERTEMP_LINE_OE, // overtemp pin enable
  output reg PIN22_IS_OVERTEMP, // pin 22 overtemp, else 2.5 V
  output reg [1:0] PIN14_FUNC, // 0 fan_speed_input_four 1 overtemp 2 alert 3 none
  output reg FAILSAFE_FULL_FAN, // force full duty
  output reg TACH_SAMPLE // tach measurement pulse
);

  reg [9:0] v12_q;
  reg [9:0] r1_q;
  reg [9:0] lt_q;
  reg [9:0] r2_q;
  reg [3:0] frz_q; // per-channel freeze, high byte pending
  reg frz_lsb_q;
  reg [7:0] cfg_a_q;
  reg [7:0] cfg_c_q;
  reg [7:0] cfg_d_q;
  reg [7:0] cfg_e_q;
  reg [7:0] lim_q;
  reg [7:0] tmr_q;
  reg ot_s1_q;
  reg ot_s2_q;
  reg ot_d_q;
  reg [31:0] tick_cnt_q;
  reg [31:0] tach_cnt_q;
  reg [7:0] rd_d;
  reg [1:0] p14_d;
  reg pin22_d;
  wire ovt_en;
  wire [1:0] p14;
  wire bidir;
  wire ot_lvl;
  wire ot_rise;
  wire [31:0] tach_lim;
  wire rd_lsb;
  wire rd_v12;
  wire rd_r1;
  wire rd_lt;
  wire rd_r2;
  wire rd_tmr;
  wire [7:0] lsb_b;
  wire [7:0] cfg_c_wr;
  wire load_ok;

  assign ovt_en = cfg_c_q[`ERPC_CFG_OVT];
  assign p14 = cfg_d_q[1:0];
  assign bidir = &cfg_e_q[`ERPC_E_BIDIR_HI:`ERPC_E_BIDIR_LO];
  assign ot_lvl = ot_s2_q & ovt_en;
  assign ot_rise = ot_lvl & ~ot_d_q;
  assign tach_lim = cfg_c_q[`ERPC_CFG_FAST] ? FAST_CYC : SLOW_CYC;
  assign rd_lsb = REG_RD && (REG_ADDR == `ERPC_ADDR_EXT_LSB_B);
  assign rd_v12 = REG_RD && (REG_ADDR == `ERPC_ADDR_MSB_V12);
  assign rd_r1 = REG_RD && (REG_ADDR == `ERPC_ADDR_MSB_R1);
  assign rd_lt = REG_RD && (REG_ADDR == `ERPC_ADDR_MSB_LT);
  assign rd_r2 = REG_RD && (REG_ADDR == `ERPC_ADDR_MSB_R2);
  assign rd_tmr = REG_RD && (REG_ADDR == `ERPC_ADDR_OVERTEMP_LINE_TMR);
  // low bits of all four channels: 12 V, remote one, local, remote two
  assign lsb_b = {r2_q[1:0], lt_q[1:0], r1_q[1:0], v12_q[1:0]};
  assign cfg_c_wr = cfg_a_q[`ERPC_LOCK_BIT] ?
    ((cfg_c_q & `ERPC_LOCK_MASK) | (REG_WDATA & ~`ERPC_LOCK_MASK)) : REG_WDATA;
  // new results only while no coherent read is pending
  assign load_ok = CONV_DONE & ~frz_lsb_q;

  // pin 14 and pin 22 decode
  always @* begin
    p14_d = `ERPC_P14_TACH;
    pin22_d = 1'b0;
    case (p14)
      `ERPC_P14_TACH: begin
        p14_d = `ERPC_P14_TACH;
        pin22_d = ovt_en;
      end
      `ERPC_P14_SEL: begin
        p14_d = ovt_en ? `ERPC_P14_SEL : `ERPC_P14_TACH;
        // overtemp moves to pin 14, so pin 22 stays on 2.5 V
        pin22_d = 1'b0;
      end
      `ERPC_P14_ALERT: begin
        p14_d = `ERPC_P14_ALERT;
        pin22_d = ovt_en;
      end
      default: begin
        p14_d = `ERPC_P14_BAD;
        pin22_d = ovt_en;
      end
    endcase
  end

  always @* begin
    rd_d = 8'h00;
    case (REG_ADDR)
      // low bits readout
      `ERPC_ADDR_EXT_LSB_B: rd_d = lsb_b;
      `ERPC_ADDR_MSB_V12: rd_d = v12_q[9:2];
      `ERPC_ADDR_MSB_R1: rd_d = r1_q[9:2];
      `ERPC_ADDR_MSB_LT: rd_d = lt_q[9:2];
      `ERPC_ADDR_MSB_R2: rd_d = r2_q[9:2];
      `ERPC_ADDR_CFG_A: rd_d = cfg_a_q;
      `ERPC_ADDR_CFG_C: rd_d = cfg_c_q;
      `ERPC_ADDR_CFG_D: rd_d = cfg_d_q;
      `ERPC_ADDR_CFG_E: rd_d = cfg_e_q;
      `ERPC_ADDR_OVERTEMP_LINE_TMR: rd_d = tmr_q;
      `ERPC_ADDR_OVERTEMP_LINE_LIM: rd_d = lim_q;
      default: rd_d = 8'h00;
    endcase
  end

  always @(posedge CLK) begin
    if (!RSTN) begin
      REG_RDATA <= 8'h00;
    end else begin
      REG_RDATA <= REG_RD ? rd_d : 8'h00;
    end
  end

  always @(posedge CLK) begin
    if (!RSTN) begin
      v12_q <= 10'h000;
      r1_q <= 10'h000;
      lt_q <= 10'h000;
      r2_q <= 10'h000;
    end else if (load_ok) begin
      if (!frz_q[0]) begin
        v12_q <= TWELVE_VOLT_INPUT;
      end
      if (!frz_q[1]) begin
        r1_q <= REMOTE_ONE_TEMP;
      end
      if (!frz_q[2]) begin
        lt_q <= LOCAL_TEMP;
      end
      if (!frz_q[3]) begin
        r2_q <= REMOTE_TWO_TEMP;
      end
    end
  end

  always @(posedge CLK) begin
    if (!RSTN) begin
      frz_q <= 4'h0;
      frz_lsb_q <= 1'b0;
    end else if (rd_lsb) begin
      frz_q <= 4'hF;
      frz_lsb_q <= 1'b1;
    end else begin
      if (rd_v12) begin
        frz_q[0] <= 1'b0;
      end
      if (rd_r1) begin
        frz_q[1] <= 1'b0;
      end
      if (rd_lt) begin
        frz_q[2] <= 1'b0;
      end
      if (rd_r2) begin
        frz_q[3] <= 1'b0;
      end
      // lsb register itself is read, so it thaws once highs are read
      if (frz_q == 4'h0) begin
        frz_lsb_q <= 1'b0;
      end
    end
  end

  always @(posedge CLK) begin
    if (!RSTN) begin
      cfg_a_q <= 8'h00;
      cfg_c_q <= `ERPC_RST_CFG_C;
      cfg_d_q <= `ERPC_RST_CFG_D;
      cfg_e_q <= `ERPC_RST_CFG_E;
      lim_q <= `ERPC_RST_LIM;
    end else if (REG_WR) begin
      case (REG_ADDR)
        `ERPC_ADDR_CFG_A: cfg_a_q <= REG_WDATA;
        `ERPC_ADDR_CFG_C: cfg_c_q <= cfg_c_wr;
        `ERPC_ADDR_CFG_D: cfg_d_q <= REG_WDATA;
        `ERPC_ADDR_CFG_E: cfg_e_q <= REG_WDATA;
        `ERPC_ADDR_OVERTEMP_LINE_LIM: lim_q <= REG_WDATA;
        default: ;
      endcase
    end
  end

  // pin is asynchronous, two flops before any logic reads it
  always @(posedge CLK) begin
    if (!RSTN) begin
      ot_s1_q <= 1'b0;
      ot_s2_q <= 1'b0;
      ot_d_q <= 1'b0;
    end else begin
      ot_s1_q <= OVERTEMP_LINE_I;
      ot_s2_q <= ot_s1_q;
      ot_d_q <= ot_lvl;
    end
  end

  // assertion timer, set wins over read clear
  always @(posedge CLK) begin
    if (!RSTN) begin
      tick_cnt_q <= 32'h0;
      tmr_q <= 8'h00;
    end else if (ot_rise) begin
      tick_cnt_q <= 32'h0;
      tmr_q <= 8'h01;
    end else if (ot_lvl) begin
      if (tick_cnt_q >= TICK_CYC - 1) begin
        tick_cnt_q <= 32'h0;
        if (tmr_q != 8'hFF) begin
          tmr_q <= tmr_q + 8'h01;
        end
      end else begin
        tick_cnt_q <= tick_cnt_q + 32'h1;
      end
    end else if (rd_tmr) begin
      tmr_q <= 8'h00;
    end
  end

  always @(posedge CLK) begin
    if (!RSTN) begin
      SHARED_PIN_O <= 1'b0;
      SHARED_IS_ALERT <= 1'b0;
      OVERTEMP_LINE_O <= 1'b0;
      OVERTEMP_LINE_OE <= 1'b0;
      PIN22_IS_OVERTEMP <= 1'b0;
      PIN14_FUNC <= 2'h0;
      FAILSAFE_FULL_FAN <= 1'b0;
    end else begin
      SHARED_IS_ALERT <= cfg_c_q[`ERPC_CFG_ALERT];
      SHARED_PIN_O <= cfg_c_q[`ERPC_CFG_ALERT] ? ALERT_REQ : FAN_DRIVE_TWO_IN;
      PIN22_IS_OVERTEMP <= pin22_d;
      PIN14_FUNC <= p14_d;
      FAILSAFE_FULL_FAN <= ot_lvl & FANS_RUNNING & cfg_c_q[`ERPC_CFG_FAILSAFE_FULL_FAN];
      // bidirectional only when enabled, open drain low
      OVERTEMP_LINE_O <= 1'b0;
      OVERTEMP_LINE_OE <= ovt_en & bidir & OVERTEMP_REQ;
    end
  end

  always @(posedge CLK) begin
    if (!RSTN) begin
      tach_cnt_q <= 32'h0;
      TACH_SAMPLE <= 1'b0;
    end else if (tach_cnt_q >= tach_lim - 1) begin
      tach_cnt_q <= 32'h0;
      TACH_SAMPLE <= 1'b1;
    end else begin
      tach_cnt_q <= tach_cnt_q + 32'h1;
      TACH_SAMPLE <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: verif/erpc_properties.sv */
`default_nettype none
module erpc_properties (
  input wire logic CLK, // clk
  input wire logic RSTN, // rst
  input wire logic [7:0] REG_ADDR, // adr
  input wire logic REG_WR, // wr
  input wire logic FAN_DRIVE_TWO_IN, // pwm
  input wire logic FANS_RUNNING, // run
  input wire logic OVERTEMP_REQ, // req
  input wire logic SHARED_PIN_O, // pin
  input wire logic SHARED_IS_ALERT, // sel
  input wire logic OVERTEMP_LINE_O, // lvl
  input wire logic OVERTEMP_LINE_OE, // oe
  input wire logic PIN22_IS_OVERTEMP, // p22
  input wire logic [1:0] PIN14_FUNC, // p14
  input wire logic FAILSAFE_FULL_FAN, // max
  input wire logic TACH_SAMPLE // tach
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  wire cfg_wr = REG_WR && REG_ADDR == 8'h78;
  wire pin_wr = cfg_wr || (REG_WR && REG_ADDR == 8'h7D);
  sequence s_quiet;
    !TACH_SAMPLE [*8];
  endsequence
  AST_FAN_DRIVE_OUTPUT_TWO: assert property (!SHARED_IS_ALERT && $past(RSTN)
    |-> SHARED_PIN_O == $past(FAN_DRIVE_TWO_IN)) else $error("fan_drive_output_two lost");
  AST_ALERT_SEL: assert property ($changed(SHARED_IS_ALERT)
    |-> $past(cfg_wr) || $past(cfg_wr, 2)) else $error("alert mode moved");
  AST_P22_SEL: assert property ($changed(PIN22_IS_OVERTEMP)
    |-> $past(pin_wr) || $past(pin_wr, 2)) else $error("pin22 moved");
  AST_FAILSAFE_FULL_FAN: assert property (FAILSAFE_FULL_FAN |-> $past(FANS_RUNNING))
    else $error("failsafe_full_fan idle fans");
  AST_OVT_LOW: assert property (OVERTEMP_LINE_O == 1'b0)
    else $error("line high");
  AST_OVT_OE: assert property (OVERTEMP_LINE_OE |-> $past(OVERTEMP_REQ))
    else $error("oe unasked");
  AST_P14_SEL: assert property (PIN14_FUNC == 2'h1 |-> !PIN22_IS_OVERTEMP)
    else $error("pin22 clash");
  AST_TACH_GAP: assert property (TACH_SAMPLE |=> s_quiet)
    else $error("tach too fast");
endmodule
bind erpc_top erpc_properties u_erpc_properties (.*);
`default_nettype wire

/* File: verif/erpc_host.sv */
`default_nettype none
module erpc_host (
  input wire logic clk, // clk
  output logic [7:0] addr = 8'h00, // adr
  output logic wr = 1'b0, // wr
  output logic [7:0] wdata = 8'h00, // dat
  output logic rd = 1'b0, // rd
  input wire logic [7:0] rdata // rdat
);
  timeunit 1ns;
  timeprecision 1ns;
  task automatic wrr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // answer is registered on the taking edge and sampled 1 ns later
  task automatic rdr(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
endmodule
`default_nettype wire

/* File: verif/ext_resolution_pin_config_tb.sv */
`default_nettype none
module ext_resolution_pin_config_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK = 1'b0, RSTN = 1'b0, CONV_DONE = 1'b0, ALERT_REQ = 1'b0, FAN_DRIVE_TWO_IN = 1'b0;
  logic FANS_RUNNING = 1'b0, OVERTEMP_LINE_I = 1'b0, OVERTEMP_REQ = 1'b0;
  logic [9:0] res [4] = '{default: 10'h000};
  wire [7:0] REG_ADDR, REG_WDATA, REG_RDATA;
  wire REG_WR, REG_RD, SHARED_PIN_O, SHARED_IS_ALERT, OVERTEMP_LINE_O, OVERTEMP_LINE_OE;
  wire PIN22_IS_OVERTEMP, FAILSAFE_FULL_FAN, TACH_SAMPLE;
  wire [1:0] PIN14_FUNC;
  int fails = 0, n_checks = 0, n;
  logic [7:0] d;
  logic [5:0] rows [8] = '{6'h00, 6'h10, 6'h22, 6'h33, 6'h0C, 6'h19, 6'h2E, 6'h3F};
  erpc_top #(.SLOW_CYC(50), .FAST_CYC(20), .TICK_CYC(10)) u_erpc_top (.*,
    .TWELVE_VOLT_INPUT(res[0]), .REMOTE_ONE_TEMP(res[1]), .LOCAL_TEMP(res[2]),
    .REMOTE_TWO_TEMP(res[3]));
  erpc_host u_erpc_host (.clk(CLK), .addr(REG_ADDR), .wr(REG_WR), .wdata(REG_WDATA),
    .rd(REG_RD), .rdata(REG_RDATA));
  initial forever #10 CLK = ~CLK;
  always @(posedge CLK) FAN_DRIVE_TWO_IN <= ~FAN_DRIVE_TWO_IN;
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    u_erpc_host.rdr(a, d);
    chk(d, e);
  endtask
  task automatic conv(input logic [9:0] a, b, c, e);
    @(posedge CLK);
    res <= '{a, b, c, e};
    CONV_DONE <= 1'b1;
    @(posedge CLK);
    CONV_DONE <= 1'b0;
  endtask
  // skip one pulse so a rate change mid-interval is not measured
  task automatic gap(input logic [7:0] e);
    repeat (2) @(posedge TACH_SAMPLE);
    n = 0;
    do begin
      @(posedge CLK);
      n++;
      #1;
    end while (TACH_SAMPLE !== 1'b1 && n < 99);
    chk(n[7:0], e);
  endtask
  task automatic end_of_test();
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge CLK);
    RSTN <= 1'b1;
    rc(8'h78, 8'h00);
    rc(8'h77, 8'h00);
    // the read above froze the set; reading every high byte thaws it
    rc(8'h24, 8'h00);
    rc(8'h25, 8'h00);
    rc(8'h26, 8'h00);
    rc(8'h27, 8'h00);
    for (int i = 0; i < 8; i++) begin
      u_erpc_host.wrr(8'h7D, {6'h00, rows[i][5:4]});
      u_erpc_host.wrr(8'h78, {6'h00, rows[i][3], i[0]});
      repeat (2) @(posedge CLK);
      #1 chk({4'h0, SHARED_IS_ALERT, PIN22_IS_OVERTEMP, PIN14_FUNC}, {4'h0, i[0], rows[i][2:0]});
    end
    conv(10'h3FD, 10'h2AE, 10'h0F3, 10'h100);
    rc(8'h77, 8'h39);
    // a newer conversion must not leak into the frozen set
    conv(10'h000, 10'h000, 10'h000, 10'h000);
    rc(8'h77, 8'h39);
    rc(8'h24, 8'hFF);
    rc(8'h25, 8'hAB);
    rc(8'h26, 8'h3C);
    rc(8'h27, 8'h40);
    conv(10'h000, 10'h000, 10'h000, 10'h000);
    u_erpc_host.wrr(8'h77, 8'hFF);
    rc(8'h77, 8'h00);
    u_erpc_host.wrr(8'h78, 8'h06);
    @(posedge CLK);
    FANS_RUNNING <= 1'b1;
    OVERTEMP_LINE_I <= 1'b1;
    ALERT_REQ <= 1'b1;
    repeat (5) @(posedge CLK);
    #1 chk({7'h00, FAILSAFE_FULL_FAN}, 8'h01);
    @(posedge CLK);
    OVERTEMP_LINE_I <= 1'b0;
    repeat (4) @(posedge CLK);
    #1 chk({7'h00, FAILSAFE_FULL_FAN}, 8'h00);
    u_erpc_host.wrr(8'h78, 8'h07);
    repeat (2) @(posedge CLK);
    #1 chk({7'h00, SHARED_PIN_O}, 8'h01);
    rc(8'h79, 8'h01);
    rc(8'h79, 8'h00);
    u_erpc_host.wrr(8'h7C, 8'hE0);
    OVERTEMP_REQ <= 1'b1;
    repeat (3) @(posedge CLK);
    #1 chk({7'h00, OVERTEMP_LINE_OE}, 8'h01);
    u_erpc_host.wrr(8'h7C, 8'hC0);
    repeat (3) @(posedge CLK);
    #1 chk({7'h00, OVERTEMP_LINE_OE}, 8'h00);
    u_erpc_host.wrr(8'h78, 8'h0E);
    gap(8'h14);
    u_erpc_host.wrr(8'h78, 8'h06);
    gap(8'h32);
    u_erpc_host.wrr(8'h40, 8'h02);
    u_erpc_host.wrr(8'h78, 8'h09);
    rc(8'h78, 8'h06);
    end_of_test();
  end
  initial begin
    repeat (5000) @(posedge CLK);
    fails++;
    end_of_test();
  end
endmodule
`default_nettype wire
